// File: dcsr_pkg.sv
// register map, field layouts and shared types of the decoder channel
// control and status bank; imported whole by every design module.
package dcsr_pkg;

	// ------------------------------------------------------------
	// register subaddresses
	// ------------------------------------------------------------
	localparam logic [7:0] DCSR_ADDR_IRQ_CLEAR_B   = 8'h1C;
	localparam logic [7:0] DCSR_ADDR_IRQ_ENABLE_B  = 8'h1D;
	localparam logic [7:0] DCSR_ADDR_IRQ_CONFIG_B  = 8'h1E;
	localparam logic [7:0] DCSR_ADDR_STANDARD      = 8'h28;
	localparam logic [7:0] DCSR_ADDR_STOP_HIGH     = 8'h29;
	localparam logic [7:0] DCSR_ADDR_STOP_LOW      = 8'h2A;
	localparam logic [7:0] DCSR_ADDR_BLUE_GAIN     = 8'h2C;
	localparam logic [7:0] DCSR_ADDR_RED_GAIN      = 8'h2D;
	localparam logic [7:0] DCSR_ADDR_TIMING_REV    = 8'h30;
	localparam logic [7:0] DCSR_ADDR_IDENT_HIGH    = 8'h80;
	localparam logic [7:0] DCSR_ADDR_IDENT_LOW     = 8'h81;
	localparam logic [7:0] DCSR_ADDR_FW_MAJOR      = 8'h82;
	localparam logic [7:0] DCSR_ADDR_FW_MINOR      = 8'h83;
	localparam logic [7:0] DCSR_ADDR_LINES_HIGH    = 8'h84;
	localparam logic [7:0] DCSR_ADDR_LINES_LOW     = 8'h85;
	localparam logic [7:0] DCSR_ADDR_IRQ_FLAGS_B   = 8'h86;
	localparam logic [7:0] DCSR_ADDR_IRQ_ACTIVE_B  = 8'h87;

	// ------------------------------------------------------------
	// reset values and field layouts
	// ------------------------------------------------------------
	localparam logic [7:0] DCSR_BYTE_ZERO          = 8'h00;
	localparam logic [3:0] DCSR_STD_RESET          = 4'h0;
	localparam logic [9:0] DCSR_STOP_RESET         = 10'h000;
	localparam logic       DCSR_REV_RESET          = 1'b0;
	localparam int         DCSR_STD_W              = 4;
	localparam int         DCSR_STOP_W             = 10;
	localparam int         DCSR_STOP_LOW_W         = 2;
	localparam int         DCSR_LINES_W            = 10;
	localparam int         DCSR_LINES_HIGH_W       = 2;
	localparam int         DCSR_FLAG_INIT          = 7;
	localparam int         DCSR_FLAG_RSVD          = 6;
	localparam int         DCSR_FLAG_CMD           = 5;
	localparam int         DCSR_FLAG_FIELD         = 4;
	localparam int         DCSR_FLAG_LINE_ALT      = 3;
	localparam int         DCSR_FLAG_COLOR         = 2;
	localparam int         DCSR_FLAG_SYNC          = 1;
	localparam int         DCSR_FLAG_SOURCE        = 0;
	localparam logic [7:0] DCSR_FLAG_WRITABLE_MASK = 8'h9F;

	// ------------------------------------------------------------
	// standard codes: automatic detection and forced standards
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		DCSR_STD_AUTO      = 4'h0,
		DCSR_STD_NTSC_M    = 4'h2,
		DCSR_STD_PAL_BGHIN = 4'h4,
		DCSR_STD_PAL_M     = 4'h6,
		DCSR_STD_PAL_CN    = 4'h8,
		DCSR_STD_NTSC_443  = 4'hA,
		DCSR_STD_SECAM     = 4'hC
	} dcsr_std_t;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic init_ready;
		logic cmd_ready;
		logic field_rate;
		logic line_alt;
		logic color_lock;
		logic sync_lock;
		logic source_type;
	} dcsr_status_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} dcsr_req_t;

endpackage

// File: dcsr_flag_bank.sv
// sticky change flags of interrupt status b
// assumes status levels arrive on clk_sys_i from the decoder core.
`timescale 1ns/1ns
`default_nettype none
module dcsr_flag_bank
	import dcsr_pkg::*;
(
	input  wire logic         clk_sys_i,
	input  wire logic         srst_i,
	input  wire dcsr_status_t status_i,
	input  wire logic [7:0]   clear_i,
	output logic [7:0]        flags_o
);
	// ------------------------------------------------------------
	// change detection
	// ------------------------------------------------------------
	logic [4:0]   prev_reg;
	logic         primed_reg;
	logic [7:0]   flags_reg;
	logic [7:0]   flags_next;
	logic [4:0]   now_w;
	logic [7:0]   set_w;

	assign now_w = {status_i.field_rate, status_i.line_alt, status_i.color_lock,
			status_i.sync_lock, status_i.source_type};
	// first cycle after reset only primes the history, no false change
	assign set_w = {status_i.init_ready, 2'b00,
			(now_w ^ prev_reg) & {5{primed_reg}}};
	// set wins over a clear in the same cycle
	assign flags_next = ((flags_reg & ~(clear_i & DCSR_FLAG_WRITABLE_MASK)) | set_w)
			& DCSR_FLAG_WRITABLE_MASK;
	assign flags_o = {flags_reg[7:6], status_i.cmd_ready & primed_reg, flags_reg[4:0]};

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			prev_reg   <= 5'h0;
			primed_reg <= 1'b0;
			flags_reg  <= DCSR_BYTE_ZERO;
		end else begin
			prev_reg   <= now_w;
			primed_reg <= 1'b1;
			flags_reg  <= flags_next;
		end
	end
endmodule
`default_nettype wire

// File: dcsr_regs.sv
// control and status register bank of one decoder channel
// assumes a serial-bus front end on clk_sys_i delivering byte writes and reads
// by subaddress; status and strobes come from decoder logic on the same clock.
//
// Behaviour
// - standard field is four bits, reset zero meaning automatic detection
// - even codes 2..C select a forced standard; odd codes are reserved
// - a written legal non-zero standard code forces that standard and clears auto_detect_o; reserved codes are dropped
// - new ten-bit stop value applies only when the low register is written
// - stop value is signed offset -512..511, reset zero
// - two read-only bytes report blue and red chroma gain in use
// - timing revision bit 0: 0 revision 4 (reset), 1 revision 3
// - fixed sixteen-bit ident, high byte at lower address
// - read-only major and minor firmware versions, 0x01..0xFF
// - ten-bit measured line count split over two registers
// - line count is measured per frame, not nominal
// - status b layout with bits reset to zero
// - command ready reads 1 only while a new command is accepted
// - change flags set on status change and stay set
// - writing 1 to clear register b clears only those flags
// - enable mask gates the pin and the irq active register, flags still set
// - active low pin is open drain; active high pin is push-pull
`timescale 1ns/1ns
`default_nettype none
module dcsr_regs
	import dcsr_pkg::*;
#(
	parameter logic [7:0] IDENT_HIGH = 8'hA5, // arbitrary value
	parameter logic [7:0] IDENT_LOW  = 8'h3C, // arbitrary value
	parameter logic [7:0] FW_MAJOR   = 8'h01, // arbitrary value
	parameter logic [7:0] FW_MINOR   = 8'h01  // arbitrary value
)(
	input  wire logic         clk_sys_i,
	input  wire logic         srst_i,
	input  wire logic [7:0]   reg_addr_i,
	input  wire logic [7:0]   reg_wdata_i,
	input  wire logic         reg_wr_i,
	input  wire logic         reg_rd_i,
	output logic [7:0]        reg_rdata_o,
	output logic              reg_rvalid_o,
	input  wire dcsr_status_t status_i,
	input  wire logic [7:0]   blue_gain_i,
	input  wire logic [7:0]   red_gain_i,
	input  wire logic         line_strobe_i,
	input  wire logic         frame_strobe_i,
	output logic [3:0]        standard_o,
	output logic              auto_detect_o,
	output logic [9:0]        stop_offset_o,
	output logic              timing_rev3_o,
	output logic              irq_b_o,
	output logic              irq_b_oe_o
);
	// ------------------------------------------------------------
	// request carrier and write decode
	// ------------------------------------------------------------
	dcsr_req_t  req_w;
	logic       wr_std_w;
	logic       wr_stop_high_w;
	logic       wr_stop_low_w;
	logic       wr_rev_w;
	logic       wr_clear_w;
	logic       wr_enable_w;
	logic       wr_config_w;
	logic       std_code_ok_w;

	assign req_w = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};

	function automatic logic hit(input dcsr_req_t r, input logic [7:0] a);
		hit = r.wr && (r.addr == a);
	endfunction

	function automatic logic std_legal(input logic [3:0] code);
		case (code)
			DCSR_STD_AUTO,
			DCSR_STD_NTSC_M,
			DCSR_STD_PAL_BGHIN,
			DCSR_STD_PAL_M,
			DCSR_STD_PAL_CN,
			DCSR_STD_NTSC_443,
			DCSR_STD_SECAM: std_legal = 1'b1;
			default:        std_legal = 1'b0;
		endcase
	endfunction

	// only the writable addresses decode; writes elsewhere fall away
	assign wr_std_w       = hit(req_w, DCSR_ADDR_STANDARD);
	assign wr_stop_high_w = hit(req_w, DCSR_ADDR_STOP_HIGH);
	assign wr_stop_low_w  = hit(req_w, DCSR_ADDR_STOP_LOW);
	assign wr_rev_w       = hit(req_w, DCSR_ADDR_TIMING_REV);
	assign wr_clear_w     = hit(req_w, DCSR_ADDR_IRQ_CLEAR_B);
	assign wr_enable_w    = hit(req_w, DCSR_ADDR_IRQ_ENABLE_B);
	assign wr_config_w    = hit(req_w, DCSR_ADDR_IRQ_CONFIG_B);
	// reserved codes would leave the decoder without a sample rate
	assign std_code_ok_w  = std_legal(req_w.wdata[DCSR_STD_W-1:0]);

	// ------------------------------------------------------------
	// control registers
	// ------------------------------------------------------------
	logic [3:0] std_reg;
	logic [3:0] std_next;
	logic [7:0] stop_high_reg;
	logic [7:0] stop_high_next;
	logic [1:0] stop_low_reg;
	logic [1:0] stop_low_next;
	logic [9:0] stop_live_reg;
	logic [9:0] stop_live_next;
	logic [9:0] stop_pair_w;
	logic       rev_reg;
	logic       rev_next;
	logic [7:0] enable_reg;
	logic [7:0] enable_next;
	logic       polarity_reg;
	logic       polarity_next;

	assign std_next = (wr_std_w && std_code_ok_w) ?
			req_w.wdata[DCSR_STD_W-1:0] : std_reg;
	assign stop_high_next = wr_stop_high_w ? req_w.wdata : stop_high_reg;
	assign stop_low_next = wr_stop_low_w ?
			req_w.wdata[DCSR_STOP_LOW_W-1:0] : stop_low_reg;
	// the pair only takes effect on the low write, so a half update never shows
	assign stop_pair_w    = {stop_high_reg, req_w.wdata[DCSR_STOP_LOW_W-1:0]};
	assign stop_live_next = wr_stop_low_w ? stop_pair_w : stop_live_reg;
	assign rev_next = wr_rev_w ? req_w.wdata[0] : rev_reg;
	assign enable_next = wr_enable_w ?
			(req_w.wdata & DCSR_FLAG_WRITABLE_MASK) : enable_reg;
	assign polarity_next = wr_config_w ? req_w.wdata[0] : polarity_reg;

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			std_reg       <= DCSR_STD_RESET;
			stop_high_reg <= DCSR_BYTE_ZERO;
			stop_low_reg  <= DCSR_STOP_RESET[DCSR_STOP_LOW_W-1:0];
			stop_live_reg <= DCSR_STOP_RESET;
			rev_reg       <= DCSR_REV_RESET;
			enable_reg    <= DCSR_BYTE_ZERO;
			polarity_reg  <= 1'b0;
		end else begin
			std_reg       <= std_next;
			stop_high_reg <= stop_high_next;
			stop_low_reg  <= stop_low_next;
			stop_live_reg <= stop_live_next;
			rev_reg       <= rev_next;
			enable_reg    <= enable_next;
			polarity_reg  <= polarity_next;
		end
	end

	assign standard_o    = std_reg;
	assign auto_detect_o = (std_reg == DCSR_STD_AUTO);
	assign stop_offset_o = stop_live_reg;
	assign timing_rev3_o = rev_reg;

	// ------------------------------------------------------------
	// measured line count
	// ------------------------------------------------------------
	// counts line strobes between frame strobes; saturates on runaway input
	logic [9:0] line_cnt_reg;
	logic [9:0] line_cnt_next;
	logic [9:0] lines_reg;
	logic [9:0] lines_next;
	logic [9:0] line_cnt_inc_w;
	logic [9:0] line_cnt_start_w;
	logic       line_cnt_full_w;

	assign line_cnt_full_w  = &line_cnt_reg;
	assign line_cnt_inc_w   = line_cnt_full_w ? line_cnt_reg : line_cnt_reg + 10'h001;
	// a line strobe on the frame edge already belongs to the next frame
	assign line_cnt_start_w = {9'h000, line_strobe_i};
	assign line_cnt_next    = frame_strobe_i ? line_cnt_start_w :
			(line_strobe_i ? line_cnt_inc_w : line_cnt_reg);
	assign lines_next      = frame_strobe_i ? line_cnt_reg : lines_reg;

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			line_cnt_reg <= 10'h000;
			lines_reg    <= 10'h000;
		end else begin
			line_cnt_reg <= line_cnt_next;
			lines_reg    <= lines_next;
		end
	end

	// ------------------------------------------------------------
	// interrupt b flags and pin
	// ------------------------------------------------------------
	logic [7:0] flags_w;
	logic [7:0] clear_w;
	logic       irq_active_w;
	logic       irq_active_reg;

	assign clear_w = wr_clear_w ? req_w.wdata : DCSR_BYTE_ZERO;

	dcsr_flag_bank u_flag_bank (
		.clk_sys_i (clk_sys_i),
		.srst_i    (srst_i),
		.status_i  (status_i),
		.clear_i   (clear_w),
		.flags_o   (flags_w)
	);

	// mask reaches the pin and the irq active register; flags set regardless
	assign irq_active_w = |(flags_w & enable_reg);

	logic       pin_level_reg;
	logic       pin_level_next;
	logic       pin_drive_reg;
	logic       pin_drive_next;

	// pin taken from flops so the open-drain enable never glitches on the board
	// active low: drive low only when active, else release
	assign pin_level_next = polarity_next ? irq_active_w : 1'b0;
	assign pin_drive_next = polarity_next ? 1'b1 : irq_active_w;

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			irq_active_reg <= 1'b0;
			pin_level_reg  <= 1'b0;
			pin_drive_reg  <= 1'b0;
		end else begin
			irq_active_reg <= irq_active_w;
			pin_level_reg  <= pin_level_next;
			pin_drive_reg  <= pin_drive_next;
		end
	end

	assign irq_b_o    = pin_level_reg;
	assign irq_b_oe_o = pin_drive_reg;

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------
	// read-only and unmapped addresses have no write decode at all
	logic [7:0] rd_sel_w;
	logic [7:0] rdata_reg;
	logic       rvalid_reg;

	function automatic logic [7:0] pad(input logic [1:0] v);
		pad = {6'h00, v};
	endfunction

	// ------------------------------------------------------------
	// read views, reserved bits forced to zero
	// ------------------------------------------------------------
	logic [7:0] view_std_w;
	logic [7:0] view_stop_low_w;
	logic [7:0] view_rev_w;
	logic [7:0] view_polarity_w;
	logic [7:0] view_lines_high_w;
	logic [7:0] view_lines_low_w;
	logic [7:0] view_active_w;

	assign view_std_w        = {4'h0, std_reg};
	assign view_stop_low_w   = pad(stop_low_reg);
	assign view_rev_w        = {7'h00, rev_reg};
	assign view_polarity_w   = {7'h00, polarity_reg};
	assign view_lines_high_w = pad(lines_reg[DCSR_LINES_W-1 -: DCSR_LINES_HIGH_W]);
	assign view_lines_low_w  = lines_reg[DCSR_LINES_W-DCSR_LINES_HIGH_W-1:0];
	assign view_active_w     = {7'h00, irq_active_reg};

	// the write-only clear register falls to the default and reads zero
	always_comb begin
		case (req_w.addr)
			DCSR_ADDR_IRQ_ENABLE_B: rd_sel_w = enable_reg;
			DCSR_ADDR_IRQ_CONFIG_B: rd_sel_w = view_polarity_w;
			DCSR_ADDR_STANDARD:     rd_sel_w = view_std_w;
			DCSR_ADDR_STOP_HIGH:    rd_sel_w = stop_high_reg;
			DCSR_ADDR_STOP_LOW:     rd_sel_w = view_stop_low_w;
			DCSR_ADDR_BLUE_GAIN:    rd_sel_w = blue_gain_i;
			DCSR_ADDR_RED_GAIN:     rd_sel_w = red_gain_i;
			DCSR_ADDR_TIMING_REV:   rd_sel_w = view_rev_w;
			DCSR_ADDR_IDENT_HIGH:   rd_sel_w = IDENT_HIGH;
			DCSR_ADDR_IDENT_LOW:    rd_sel_w = IDENT_LOW;
			DCSR_ADDR_FW_MAJOR:     rd_sel_w = FW_MAJOR;
			DCSR_ADDR_FW_MINOR:     rd_sel_w = FW_MINOR;
			DCSR_ADDR_LINES_HIGH:   rd_sel_w = view_lines_high_w;
			DCSR_ADDR_LINES_LOW:    rd_sel_w = view_lines_low_w;
			DCSR_ADDR_IRQ_FLAGS_B:  rd_sel_w = flags_w;
			DCSR_ADDR_IRQ_ACTIVE_B: rd_sel_w = view_active_w;
			default:                rd_sel_w = DCSR_BYTE_ZERO;
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			rdata_reg  <= DCSR_BYTE_ZERO;
			rvalid_reg <= 1'b0;
		end else begin
			rdata_reg  <= req_w.rd ? rd_sel_w : rdata_reg;
			rvalid_reg <= req_w.rd;
		end
	end

	assign reg_rdata_o  = rdata_reg;
	assign reg_rvalid_o = rvalid_reg;
endmodule
`default_nettype wire

// File: dcsr_regs_sva.sv
// assertions on the ports of the decoder channel register bank
// assumes one clock domain and the bank's synchronous reset
`timescale 1ns/1ns
`default_nettype none
module dcsr_regs_sva
	import dcsr_pkg::*;
#(
	parameter logic [7:0] IDENT_HIGH = 8'hA5, // arbitrary value
	parameter logic [7:0] IDENT_LOW  = 8'h3C  // arbitrary value
)(
	input wire logic         clk_sys_i,
	input wire logic         srst_i,
	input wire logic [7:0]   reg_addr_i,
	input wire logic [7:0]   reg_wdata_i,
	input wire logic         reg_wr_i,
	input wire logic         reg_rd_i,
	input wire logic [7:0]   reg_rdata_o,
	input wire logic         reg_rvalid_o,
	input wire dcsr_status_t status_i,
	input wire logic [7:0]   blue_gain_i,
	input wire logic [3:0]   standard_o,
	input wire logic         auto_detect_o,
	input wire logic [9:0]   stop_offset_o,
	input wire logic         timing_rev3_o,
	input wire logic         irq_b_o,
	input wire logic         irq_b_oe_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (srst_i);
	chk_gain_read:
	assert property (reg_rd_i && reg_addr_i == 8'h2C |=>
		reg_rvalid_o && reg_rdata_o == $past(blue_gain_i)) else $error("gain read wrong");
	chk_ident_high:
	assert property (reg_rd_i && reg_addr_i == 8'h80 |=> reg_rdata_o == IDENT_HIGH)
		else $error("ident high wrong");
	chk_ident_low:
	assert property (reg_rd_i && reg_addr_i == 8'h81 |=> reg_rdata_o == IDENT_LOW)
		else $error("ident low wrong");
	chk_fw_nonzero:
	assert property (reg_rd_i && reg_addr_i[7:1] == 7'h41 |=> reg_rdata_o != 8'h00)
		else $error("version reads zero");
	chk_stop_waits_low:
	assert property (reg_wr_i && reg_addr_i == 8'h29 |=> $stable(stop_offset_o))
		else $error("stop moved on high write");
	chk_stop_low_apply:
	assert property (reg_wr_i && reg_addr_i == 8'h2A |=>
		stop_offset_o[1:0] == $past(reg_wdata_i[1:0])) else $error("stop not applied");
	chk_odd_std_kept:
	assert property (reg_wr_i && reg_addr_i == 8'h28 && reg_wdata_i[0] |=> $stable(standard_o))
		else $error("reserved code taken");
	chk_auto_level:
	assert property (auto_detect_o == (standard_o == 4'h0)) else $error("auto flag wrong");
	chk_rev_select:
	assert property (reg_wr_i && reg_addr_i == 8'h30 |=> timing_rev3_o == $past(reg_wdata_i[0]))
		else $error("revision select wrong");
	chk_sync_flag_set:
	assert property (!$past(srst_i) && $changed(status_i.sync_lock) ##[1:3]
		(reg_rd_i && reg_addr_i == 8'h86 && !reg_wr_i) |=> reg_rdata_o[1])
		else $error("sync flag missing");
	chk_rsvd_flag_zero:
	assert property (reg_rd_i && reg_addr_i == 8'h86 |=> !reg_rdata_o[6])
		else $error("reserved flag set");
	chk_pin_idle_low:
	assert property (!irq_b_oe_o |-> !irq_b_o) else $error("undriven pin value high");
	cover property (reg_wr_i && reg_addr_i == 8'h2A);
	cover property (reg_rd_i && reg_addr_i == 8'h86);
	cover property (irq_b_oe_o && irq_b_o);
endmodule
bind dcsr_regs dcsr_regs_sva #(.IDENT_HIGH(IDENT_HIGH), .IDENT_LOW(IDENT_LOW)) u_sva (
	.clk_sys_i, .srst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
	.reg_rvalid_o, .status_i, .blue_gain_i, .standard_o, .auto_detect_o, .stop_offset_o,
	.timing_rev3_o, .irq_b_o, .irq_b_oe_o);
`default_nettype wire

// File: dcsr_host_model.sv
// host side of the subaddress port: byte writes and polled reads
// driven at the falling edge; the testbench calls its tasks
`timescale 1ns/1ns
`default_nettype none
module dcsr_host_model (
	input  wire logic       clk_sys_i,
	output logic [7:0]      addr_o,
	output logic [7:0]      wdata_o,
	output logic            wr_o,
	output logic            rd_o,
	input  wire logic [7:0] rdata_i,
	input  wire logic       rvalid_i
);
	initial begin
		addr_o = 8'h00;
		wdata_o = 8'h00;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end
	// released lines show the inverse so a stale byte never looks valid
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys_i);
		addr_o = a;
		wdata_o = d;
		wr_o = 1'b1;
		@(negedge clk_sys_i);
		wr_o = 1'b0;
		addr_o = ~a;
		wdata_o = ~d;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d, output logic v);
		@(negedge clk_sys_i);
		addr_o = a;
		rd_o = 1'b1;
		@(negedge clk_sys_i);
		rd_o = 1'b0;
		addr_o = ~a;
		d = rdata_i;
		v = rvalid_i;
	endtask
endmodule
`default_nettype wire

// File: testbench.sv
// self-checking bench for the decoder channel register bank
// host model drives the port; status and strobes come from here
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import dcsr_pkg::*;
	logic         clk;
	logic         srst;
	dcsr_status_t status;
	logic [7:0]   addr;
	logic [7:0]   wdata;
	logic         wr;
	logic         rd;
	logic [7:0]   rdata;
	logic         rvalid;
	logic         line_s;
	logic         frame_s;
	logic [3:0]   std;
	logic         auto_det;
	logic [9:0]   stop;
	logic         rev3;
	logic         irq;
	logic         irq_oe;
	int           n_fail = 0;
	int           tests_run = 0;

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	dcsr_host_model u_host (.clk_sys_i(clk), .addr_o(addr), .wdata_o(wdata), .wr_o(wr),
		.rd_o(rd), .rdata_i(rdata), .rvalid_i(rvalid));
	dcsr_regs u_dut (.clk_sys_i(clk), .srst_i(srst), .reg_addr_i(addr), .reg_wdata_i(wdata),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
		.status_i(status), .blue_gain_i(8'h5A), .red_gain_i(8'hC3), .line_strobe_i(line_s),
		.frame_strobe_i(frame_s), .standard_o(std), .auto_detect_o(auto_det),
		.stop_offset_o(stop), .timing_rev3_o(rev3), .irq_b_o(irq), .irq_b_oe_o(irq_oe));

	task automatic chk8(input logic [7:0] g, input logic [7:0] e);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("Error at %0t: read %h expected %h", $time, g, e);
		end
	endtask
	task automatic chk10(input logic [9:0] g, input logic [9:0] e);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("Error at %0t: output %h expected %h", $time, g, e);
		end
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic       v;
		u_host.rd_reg(a, d, v);
		chk10(10'(v), 10'h001);
		chk8(d, e);
	endtask
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	task automatic t_reset;
		chk10(10'({std, auto_det}), 10'h001);
		chk10(stop, 10'h000);
		chk10(10'(rev3), 10'h000);
		rd_chk(8'h86, 8'h00);
		rd_chk(8'h2A, 8'h00);
		rd_chk(8'h40, 8'h00);
		$display("reset test done");
	endtask
	task automatic t_std;
		logic [3:0] e;
		e = 4'h0;
		for (int c = 0; c < 16; c++) begin
			u_host.wr_reg(8'h28, c[7:0]);
			if (!c[0] && c <= 12) e = c[3:0];
			chk10(10'({std, auto_det}), 10'({e, e == 4'h0}));
			rd_chk(8'h28, 8'(e));
		end
		u_host.wr_reg(8'h28, 8'h00);
		chk10(10'(auto_det), 10'h001);
		$display("standard test done");
	endtask
	task automatic t_stop;
		u_host.wr_reg(8'h29, 8'h80);
		chk10(stop, 10'h000);
		rd_chk(8'h29, 8'h80);
		u_host.wr_reg(8'h2A, 8'hFF);
		chk10(stop, 10'h203);
		rd_chk(8'h2A, 8'h03);
		u_host.wr_reg(8'h29, 8'h7F);
		u_host.wr_reg(8'h2A, 8'h03);
		chk10(stop, 10'h1FF);
		// back to the default window, whose pixel count is even
		u_host.wr_reg(8'h29, 8'h00);
		chk10(stop, 10'h1FF);
		u_host.wr_reg(8'h2A, 8'h00);
		chk10(stop, 10'h000);
		$display("stop test done");
	endtask
	task automatic t_rev;
		u_host.wr_reg(8'h30, 8'hFF);
		chk10(10'(rev3), 10'h001);
		rd_chk(8'h30, 8'h01);
		u_host.wr_reg(8'h30, 8'h00);
		chk10(10'(rev3), 10'h000);
		$display("revision test done");
	endtask
	task automatic t_ro;
		u_host.wr_reg(8'h80, 8'hFF);
		u_host.wr_reg(8'h82, 8'hFF);
		u_host.wr_reg(8'h2C, 8'hFF);
		u_host.wr_reg(8'h86, 8'hFF);
		rd_chk(8'h80, 8'hA5);
		rd_chk(8'h81, 8'h3C);
		rd_chk(8'h82, 8'h01);
		rd_chk(8'h83, 8'h01);
		rd_chk(8'h2C, 8'h5A);
		rd_chk(8'h2D, 8'hC3);
		rd_chk(8'h86, 8'h00);
		$display("read-only test done");
	endtask
	task automatic t_lines;
		for (int n = 0; n < 302; n++) begin
			@(negedge clk);
			frame_s = (n == 0 || n == 301);
			line_s = !frame_s;
			@(negedge clk);
			frame_s = 1'b0;
			line_s = 1'b0;
		end
		rd_chk(8'h84, 8'h01);
		rd_chk(8'h85, 8'h2C);
		$display("line count test done");
	endtask
	task automatic t_flags;
		@(negedge clk);
		status = 7'h7F;
		@(negedge clk);
		status.init_ready = 1'b0;
		rd_chk(8'h86, 8'hBF);
		u_host.wr_reg(8'h1C, 8'h05);
		rd_chk(8'h86, 8'hBA);
		u_host.wr_reg(8'h1C, 8'hFF);
		rd_chk(8'h86, 8'h20);
		status.cmd_ready = 1'b0;
		rd_chk(8'h86, 8'h00);
		u_host.wr_reg(8'h1D, 8'h02);
		status.sync_lock = 1'b0;
		repeat (3) @(negedge clk);
		chk10(10'({irq_oe, irq}), 10'h002);
		rd_chk(8'h87, 8'h01);
		u_host.wr_reg(8'h1C, 8'h02);
		repeat (2) @(negedge clk);
		chk10(10'({irq_oe, irq}), 10'h000);
		u_host.wr_reg(8'h1E, 8'h01);
		repeat (2) @(negedge clk);
		chk10(10'({irq_oe, irq}), 10'h002);
		status.sync_lock = 1'b1;
		repeat (3) @(negedge clk);
		chk10(10'({irq_oe, irq}), 10'h003);
		$display("flag test done");
	endtask

	initial begin
		srst = 1'b1;
		status = '0;
		line_s = 1'b0;
		frame_s = 1'b0;
		repeat (2) @(negedge clk);
		srst = 1'b0;
		t_reset;
		t_std;
		t_stop;
		t_rev;
		t_ro;
		t_lines;
		t_flags;
		stop_test;
	end
	// a hang ends in the same report
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		$display("Error at %0t: run hung", $time);
		stop_test;
	end
endmodule
`default_nettype wire
